// File: dsp_board_chk.sv
// Checker: board decode and read wait state at the top ports.
// Assumes one clock; bound to dsp_board_top by the bench.
`timescale 1ns/100ps
module dsp_board_chk (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  // Bus requests
  input wire logic [5:0] board_addr_i,
  input wire logic [7:0] addr_i,
  input wire logic       io_read_status_i,
  input wire logic       io_write_status_i,
  input wire logic       wait_acknowledge_i,
  // Board answers
  input wire logic       data_oe_o,
  input wire logic       rw_n_o,
  input wire logic       bus_ready_line_o
);
  logic       rd_sel;  // Read aimed at this board
  logic       wr_sel;  // Write aimed at this board
  logic [7:0] low_cnt; // Wait cycles so far
  assign rd_sel = io_read_status_i && (addr_i[7:2] == board_addr_i);
  assign wr_sel = io_write_status_i && (addr_i[7:2] == board_addr_i);
  // Wait length; an 8-bit count is ample for a 25-cycle stall
  always_ff @(posedge ref_clk_i) begin
    low_cnt <= (!reset_n_i || bus_ready_line_o) ? 8'h00 : low_cnt + 8'h01;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  //////////////////////////////
  property p_wait_start; $rose(rd_sel) |=> !bus_ready_line_o; endproperty
  a_wait_start: assert property (p_wait_start) else $error("read not stalled");
  property p_wait_hold; $fell(bus_ready_line_o) |=> !bus_ready_line_o [*8]; endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait broke off");
  property p_wait_min; $rose(bus_ready_line_o) |-> low_cnt >= 8'h19; endproperty
  a_wait_min: assert property (p_wait_min) else $error("wait too short");
  property p_no_wr_wait; bus_ready_line_o && !rd_sel |=> bus_ready_line_o; endproperty
  a_no_wr_wait: assert property (p_no_wr_wait) else $error("wait without read");
  property p_ack_only; $rose(bus_ready_line_o) |-> $past(wait_acknowledge_i); endproperty
  a_ack_only: assert property (p_ack_only) else $error("ready without ack");
  property p_ack_rel; !bus_ready_line_o && wait_acknowledge_i && low_cnt >= 8'h18 |-> ##[1:3] bus_ready_line_o;
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack ignored");
  property p_rd_sel; 1'b1 |=> data_oe_o == $past(rd_sel); endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("bad read select");
  property p_wr_sel; 1'b1 |=> rw_n_o == !$past(wr_sel); endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("bad write select");
endmodule // dsp_board_chk

// File: dsp_board_top.sv
// Dual serial port board: bus decode, read wait state and two serial ports.
// Assumes CPU bus signals synchronous to ref_clk_i and serial lines at logic level.
//
// Summary of operation
// - Receive full sets on character transfer
// - Receive full clears on read, reset, carrier
// - Transmit empty low until transmission starts
// - Carrier loss sets bit and interrupt
// - Carrier bit latched until status, data read
// - CTS bit mirrors input, inhibits transmit empty
// - Framing fault on missing first stop
// - Overrun on second unread character
// - Overrun shown after prior character read
// - Data read or reset clears overrun
// - Parity fault held with its character
// - No-parity formats send and check none
// - Status bit seven mirrors interrupt output
// - Board selected on address and I/O
// - A1 picks port, A0 picks register
// - Access strobe from write or read strobe
// - Writes select port, direction line low
// - Reads stall bus ready 500 ns
// - Wait acknowledge releases; reads only
// - Power-on clear clears wait flip-flop
// - Control bits 1:0 divide or reset
// - Control bits 4:2 character format
// - Control bits 7:5 RTS, interrupts, break
`timescale 1ns/100ps
`include "dsp_cfg.svh"

module dsp_board_top #(
  parameter int RATE_DIV = 326  // Reference clocks per rate tick
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               power_on_clear_i,
  // Board address jumpers, matched against A7-A2
  input  wire logic [5:0]         board_addr_i,
  // CPU I/O bus
  input  wire logic [7:0]         addr_i,
  input  wire dsp_pkg::dsp_byte_t data_i,
  input  wire logic               io_read_status_i,
  input  wire logic               io_write_status_i,
  input  wire logic               data_in_strobe_i,
  input  wire logic               write_strobe_n_i,
  input  wire logic               wait_acknowledge_i,
  output dsp_pkg::dsp_byte_t      data_o,
  output logic                    data_oe_o,
  output logic                    rw_n_o,
  output logic                    bus_ready_line_o,
  // Serial side, one bit per port
  input  wire logic [1:0]         rxd_i,
  input  wire logic [1:0]         cts_n_i,
  input  wire logic [1:0]         dcd_n_i,
  output logic [1:0]              txd_o,
  output logic [1:0]              rts_n_o,
  output logic [1:0]              irq_n_o
);
  import dsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bit length in rate ticks for a divide code
  function automatic logic [6:0] bit_len(input logic [1:0] div);
    case (div)
      `DSP_DIV_16: bit_len = 7'h10;
      `DSP_DIV_64: bit_len = 7'h40;
      default:     bit_len = 7'h01;
    endcase
  endfunction

  // Parity present in this format
  function automatic logic fmt_par_en(input logic [2:0] fmt);
    fmt_par_en = (fmt != 3'h4) && (fmt != 3'h5);
  endfunction

  // Two stop bits in this format
  function automatic logic fmt_stop2(input logic [2:0] fmt);
    fmt_stop2 = (fmt == 3'h0) || (fmt == 3'h1) || (fmt == 3'h4);
  endfunction

  // Index of the last data bit: 7 or 8 data bits
  function automatic logic [2:0] fmt_last(input logic [2:0] fmt);
    fmt_last = fmt[2] ? 3'h7 : 3'h6;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode and access strobe

  localparam logic [4:0] WAIT_CYC = 5'(`DSP_WAIT_CYC);

  logic      board_select_n;  // Low while this board is addressed
  logic      port_chip_select; // Selected port
  logic      register_select;  // Control/status or data
  logic      access_strobe;   // Register access window
  logic      strobe_q;        // Strobe one cycle late, for edges
  logic      rd_pulse;        // First cycle of a read access
  logic      wr_pulse;        // First cycle of a write access
  logic      rd_sel;          // Board addressed by an input cycle
  logic      rd_sel_q;        // Previous rd_sel
  logic [4:0] wait_cnt;       // Cycles left in the least wait
  logic      rate_tick;       // Shared 16x rate clock tick
  dsp_byte_t status [2];      // Assembled status words
  dsp_byte_t rx_hold [2];     // Receive holding registers
  dsp_byte_t ctrl [2];        // Control registers

  // address match with an I/O cycle
  assign board_select_n = !((addr_i[7:2] == board_addr_i) && (io_read_status_i || io_write_status_i));
  assign port_chip_select = addr_i[1];
  assign register_select  = addr_i[0];
  assign access_strobe = !board_select_n && (data_in_strobe_i || !write_strobe_n_i);
  assign rd_pulse = access_strobe && !strobe_q && io_read_status_i && data_in_strobe_i;
  assign wr_pulse = access_strobe && !strobe_q && io_write_status_i && !write_strobe_n_i;
  assign rd_sel   = !board_select_n && io_read_status_i;

  // Strobe edge tracking; one register effect per machine cycle
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= access_strobe;
    end
  end

  // Read data, driver enable and direction line
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
      rw_n_o    <= 1'b1;
    end else begin
      data_oe_o <= rd_sel;
      rw_n_o    <= !(!board_select_n && io_write_status_i);
      if (rd_sel) begin
        data_o <= register_select ? rx_hold[port_chip_select] : status[port_chip_select];
      end
    end
  end

  // Wait flip-flop; hold off the CPU so address settles before data is read.
  // The ready line stays low at least the least time even if acknowledge is early.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || power_on_clear_i) begin
      bus_ready_line_o <= 1'b1;
      wait_cnt         <= 5'h00;
      rd_sel_q         <= 1'b0;
    end else begin
      rd_sel_q <= rd_sel;
      if (rd_sel && !rd_sel_q) begin
        bus_ready_line_o <= 1'b0;
        wait_cnt         <= WAIT_CYC - 5'h01;
      end else if (!bus_ready_line_o) begin
        if (wait_cnt != 5'h00) begin
          wait_cnt <= wait_cnt - 5'h01;
        end else if (wait_acknowledge_i) begin
          bus_ready_line_o <= 1'b1;
        end
      end
    end
  end

  // Shared rate clock for both ports
  dsp_rate_tick #(.RATE_DIV(RATE_DIV)) u_rate (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .tick_o    (rate_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial ports

  for (genvar g = 0; g < 2; g++) begin : g_port
    logic        here;      // This port addressed
    logic        wr_ctl;    // Control write
    logic        wr_dat;    // Data write
    logic        rd_st;     // Status read
    logic        rd_dat;    // Data read
    logic        mrst;      // Master reset held
    logic [2:0]  fmt;       // Character format
    logic [6:0]  len;       // Bit length in ticks
    logic        buf_rdy;   // Holding stage has room
    logic        buf_valid; // Character waiting to send
    dsp_byte_t   buf_data;  // Character waiting to send
    logic        tx_take;   // Transmitter free
    logic        tx_end;    // End of a transmit bit
    dsp_ser_st_t tx_st;
    logic [6:0]  tx_ph;
    logic [2:0]  tx_idx;
    logic        tx_par;
    logic        tx_two;    // Second stop bit still to send
    dsp_byte_t   tx_sh;
    dsp_ser_st_t rx_st;
    logic [6:0]  rx_ph;
    logic [2:0]  rx_idx;
    logic        rx_par;    // Received parity bit
    dsp_byte_t   rx_sh;
    logic        rx_mid;    // Middle of start bit
    logic        rx_end;    // Sample point of later bits
    logic        rx_done;   // Character complete at first stop
    dsp_byte_t   rx_data;
    logic        rx_pe;
    logic        rx_holding_full;      // Receive full
    logic        ovr_pend;  // Overrun waiting behind a good char
    logic        ovr_vis;   // Overrun shown in status
    logic        fe;
    logic        pe;
    logic        rd_frees;  // Data read empties holding register
    logic        dcd_lat;   // Carrier loss latch
    logic        dcd_seen;  // Status read while carrier bit set
    logic        tx_holding_empty;
    logic        irq;

    assign here   = (port_chip_select == 1'(g));
    assign wr_ctl = wr_pulse && here && (register_select == `DSP_RS_CTRL);
    assign wr_dat = wr_pulse && here && (register_select == `DSP_RS_DATA);
    assign rd_st  = rd_pulse && here && (register_select == `DSP_RS_CTRL);
    assign rd_dat = rd_pulse && here && (register_select == `DSP_RS_DATA);
    assign mrst   = (ctrl[g][`DSP_CT_DIV] == `DSP_DIV_MRST);
    assign fmt    = ctrl[g][`DSP_CT_FMT];
    assign len    = bit_len(ctrl[g][`DSP_CT_DIV]);

    // Control register; reset leaves the port in master reset
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        ctrl[g] <= `DSP_CTRL_RST;
      end else if (wr_ctl) begin
        ctrl[g] <= data_i;
      end
    end

    // Transmit holding stage; a full stage drops further writes
    dsp_skid_buf #(.WIDTH(8), .DEPTH(2)) u_tx_buf (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .clr_i       (mrst),
      .in_valid_i  (wr_dat),
      .in_ready_o  (buf_rdy),
      .in_data_i   (data_i),
      .out_valid_o (buf_valid),
      .out_ready_i (tx_take),
      .out_data_o  (buf_data)
    );

    assign tx_take = (tx_st == SER_IDLE) && !mrst;
    assign tx_end  = rate_tick && (tx_ph == len - 7'h01);

    // Transmit shifter
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || mrst) begin
        tx_st  <= SER_IDLE;
        tx_ph  <= 7'h00;
        tx_idx <= 3'h0;
        tx_par <= 1'b0;
        tx_two <= 1'b0;
        tx_sh  <= 8'h00;
      end else begin
        if ((tx_st == SER_IDLE) || tx_end) begin
          tx_ph <= 7'h00;
        end else if (rate_tick) begin
          tx_ph <= tx_ph + 7'h01;
        end
        unique case (tx_st)
          SER_IDLE: if (buf_valid) begin
            tx_sh  <= buf_data;
            tx_par <= fmt[0];
            tx_idx <= 3'h0;
            tx_st  <= SER_START;
          end
          SER_START: if (tx_end) begin
            tx_st <= SER_DATA;
          end
          SER_DATA: if (tx_end) begin
            tx_par <= tx_par ^ tx_sh[0];
            tx_sh  <= tx_sh >> 1;
            tx_idx <= tx_idx + 3'h1;
            tx_two <= fmt_stop2(fmt);
            if (tx_idx == fmt_last(fmt)) begin
              tx_st <= fmt_par_en(fmt) ? SER_PAR : SER_STOP;
            end
          end
          SER_PAR: if (tx_end) begin
            tx_st <= SER_STOP;
          end
          SER_STOP: if (tx_end) begin
            if (tx_two) begin
              tx_two <= 1'b0;
            end else begin
              tx_st <= SER_IDLE;
            end
          end
        endcase
      end
    end

    // Line drivers: data, break and request-to-send
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        txd_o[g]   <= 1'b1;
        rts_n_o[g] <= 1'b1;
      end else begin
        rts_n_o[g] <= ctrl[g][6];
        if (ctrl[g][`DSP_CT_TXC] == `DSP_TXC_BRK) begin
          txd_o[g] <= 1'b0;
        end else begin
          unique case (tx_st)
            SER_START: txd_o[g] <= 1'b0;
            SER_DATA:  txd_o[g] <= tx_sh[0];
            SER_PAR:   txd_o[g] <= tx_par;
            SER_IDLE,
            SER_STOP:  txd_o[g] <= 1'b1;
          endcase
        end
      end
    end

    assign rx_mid  = rate_tick && (rx_ph == (len >> 1));
    assign rx_end  = rate_tick && (rx_ph == len - 7'h01);
    assign rx_done = (rx_st == SER_STOP) && rx_end;
    assign rx_data = fmt[2] ? rx_sh : {1'b0, rx_sh[7:1]};
    assign rx_pe   = fmt_par_en(fmt) && (^rx_data ^ rx_par ^ fmt[0]);

    // Receive shifter; keeps running through an overrun so framing holds
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || mrst) begin
        rx_st  <= SER_IDLE;
        rx_ph  <= 7'h00;
        rx_idx <= 3'h0;
        rx_par <= 1'b0;
        rx_sh  <= 8'h00;
      end else begin
        if ((rx_st == SER_IDLE) || ((rx_st == SER_START) && rx_mid) || rx_end) begin
          rx_ph <= 7'h00;
        end else if (rate_tick) begin
          rx_ph <= rx_ph + 7'h01;
        end
        unique case (rx_st)
          SER_IDLE: if (!rxd_i[g]) begin
            rx_st <= SER_START;
          end
          // A start bit gone high by mid bit was noise
          SER_START: if (rx_mid) begin
            rx_st  <= rxd_i[g] ? SER_IDLE : SER_DATA;
            rx_idx <= 3'h0;
          end
          SER_DATA: if (rx_end) begin
            rx_sh  <= {rxd_i[g], rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == fmt_last(fmt)) begin
              rx_st <= fmt_par_en(fmt) ? SER_PAR : SER_STOP;
            end
          end
          SER_PAR: if (rx_end) begin
            rx_par <= rxd_i[g];
            rx_st  <= SER_STOP;
          end
          SER_STOP: if (rx_end) begin
            rx_st <= SER_IDLE;
          end
        endcase
      end
    end

    // A read frees the holding register unless it only uncovers an overrun
    assign rd_frees = rd_dat && !(ovr_pend && !ovr_vis);

    // Receive holding register and its flags; a new character beats a clear
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || mrst) begin
        rx_holding_full       <= 1'b0;
        ovr_pend   <= 1'b0;
        ovr_vis    <= 1'b0;
        fe         <= 1'b0;
        pe         <= 1'b0;
        rx_hold[g] <= 8'h00;
      end else begin
        if (rd_dat) begin
          if (ovr_vis) begin
            ovr_vis <= 1'b0;
            rx_holding_full    <= 1'b0;
          end else if (ovr_pend) begin
            ovr_vis  <= 1'b1;
            ovr_pend <= 1'b0;
          end else begin
            rx_holding_full <= 1'b0;
          end
        end
        if (rx_done) begin
          if (!rx_holding_full || rd_frees) begin
            rx_holding_full       <= 1'b1;
            rx_hold[g] <= rx_data;
            fe         <= !rxd_i[g];
            pe         <= rx_pe;
          end else begin
            ovr_pend <= 1'b1;
          end
        end
      end
    end

    // Carrier loss latch
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        dcd_lat  <= 1'b0;
        dcd_seen <= 1'b0;
      end else begin
        if (dcd_n_i[g]) begin
          dcd_lat <= 1'b1;
        end else if (mrst || (rd_dat && dcd_seen)) begin
          dcd_lat <= 1'b0;
        end
        if (mrst || rd_dat) begin
          dcd_seen <= 1'b0;
        end else if (rd_st && dcd_lat) begin
          dcd_seen <= 1'b1;
        end
      end
    end

    assign tx_holding_empty = !buf_valid && buf_rdy && !cts_n_i[g];
    assign irq  = (ctrl[g][`DSP_CT_RIE] && (rx_holding_full || ovr_vis || dcd_lat)) ||
                  ((ctrl[g][`DSP_CT_TXC] == `DSP_TXC_IE) && tx_holding_empty);

    // Interrupt output
    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        irq_n_o[g] <= 1'b1;
      end else begin
        irq_n_o[g] <= !irq;
      end
    end

    // Status word assembly
    always_comb begin
      status[g] = 8'h00;
      status[g][`DSP_ST_RXF] = rx_holding_full && !dcd_n_i[g];
      status[g][`DSP_ST_TXE] = tx_holding_empty;
      status[g][`DSP_ST_DCD] = dcd_lat;
      status[g][`DSP_ST_CTS] = cts_n_i[g];
      status[g][`DSP_ST_FE]  = fe;
      status[g][`DSP_ST_OVR] = ovr_vis;
      status[g][`DSP_ST_PE]  = pe;
      status[g][`DSP_ST_IRQ] = !irq_n_o[g];
    end
  end
endmodule // dsp_board_top

// File: dsp_board_top_test.sv
// Bench: CPU model on the bus; port 0 transmit feeds port 1 receive.
// Assumes dsp_cpu_model and dsp_board_chk; board jumpered at 8'h44.
`timescale 1ns/100ps
module dsp_board_top_test;
  import dsp_pkg::*;
  logic       ref_clk_i, reset_n_i, power_on_clear_i;
  logic [7:0] addr_i;
  dsp_byte_t  data_i, data_o, rd_val;
  logic       io_read_status_i, io_write_status_i, data_in_strobe_i, write_strobe_n_i;
  logic       wait_acknowledge_i, data_oe_o, rw_n_o, bus_ready_line_o;
  logic [1:0] txd_o, rts_n_o, irq_n_o, cts_n_i, dcd_n_i;
  int         num_errors, comparisons;
  dsp_cpu_model cpu_u (.ref_clk_i, .rdata_i(data_o), .ready_i(bus_ready_line_o), .addr_o(addr_i),
    .wdata_o(data_i), .rd_stat_o(io_read_status_i), .wr_stat_o(io_write_status_i),
    .din_o(data_in_strobe_i), .wr_n_o(write_strobe_n_i), .wack_o(wait_acknowledge_i));
  // Small rate divide keeps a character near 350 clocks
  dsp_board_top #(.RATE_DIV(2)) dut_u (.ref_clk_i, .reset_n_i, .power_on_clear_i, .board_addr_i(6'h11),
    .addr_i, .data_i, .io_read_status_i, .io_write_status_i, .data_in_strobe_i, .write_strobe_n_i,
    .wait_acknowledge_i, .data_o, .data_oe_o, .rw_n_o, .bus_ready_line_o, .rxd_i({txd_o[0], txd_o[1]}),
    .cts_n_i, .dcd_n_i, .txd_o, .rts_n_o, .irq_n_o);
  //////////////////////////////
  task automatic check(input dsp_byte_t seen, input dsp_byte_t exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input dsp_byte_t exp);
    cpu_u.io_rd(a, rd_val);
    check(rd_val, exp);
    check({7'h00, bus_ready_line_o}, 8'h01);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Watchdog: the sequence needs about 1900 clocks
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    num_errors = 0;
    comparisons = 0;
    {reset_n_i, power_on_clear_i, cts_n_i, dcd_n_i} = 6'h18;
    repeat (10) @(posedge ref_clk_i);
    #1;
    {reset_n_i, power_on_clear_i} = 2'h2;
    cpu_u.io_wr(8'h46, 8'h15);
    rd_chk(8'h46, 8'h08);
    cpu_u.io_wr(8'h44, 8'h59);
    cpu_u.io_wr(8'h46, 8'h9D);
    rd_chk(8'h44, 8'h02);
    check({6'h00, rts_n_o}, 8'h01);
    cpu_u.io_rd(8'h40, rd_val);
    cts_n_i = 2'h0;
    cpu_u.io_wr(8'h45, 8'h5A);
    repeat (500) @(posedge ref_clk_i);
    rd_chk(8'h46, 8'hC3);
    check({6'h00, irq_n_o}, 8'h01);
    rd_chk(8'h47, 8'h5A);
    rd_chk(8'h46, 8'h42);
    cpu_u.io_wr(8'h45, 8'h11);
    cpu_u.io_wr(8'h45, 8'h22);
    repeat (900) @(posedge ref_clk_i);
    rd_chk(8'h46, 8'hC3);
    rd_chk(8'h47, 8'h11);
    rd_chk(8'h46, 8'hE3);
    rd_chk(8'h47, 8'h11);
    rd_chk(8'h46, 8'h42);
    dcd_n_i = 2'h2;
    rd_chk(8'h46, 8'hC6);
    dcd_n_i = 2'h0;
    rd_chk(8'h46, 8'hC6);
    rd_chk(8'h47, 8'h11);
    rd_chk(8'h46, 8'h42);
    cts_n_i = 2'h2;
    cpu_u.io_wr(8'h46, 8'h03);
    rd_chk(8'h46, 8'h08);
    complete_run();
  end
endmodule // dsp_board_top_test
bind dsp_board_top dsp_board_chk chk_u (.ref_clk_i, .reset_n_i, .board_addr_i, .addr_i, .io_read_status_i,
  .io_write_status_i, .wait_acknowledge_i, .data_oe_o, .rw_n_o, .bus_ready_line_o);

// File: dsp_cfg.svh
// Constants for the dual serial port board: field positions, resets, timing.
// Included by bare name from dsp_board_top.
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH
// Register select within a port, address bit 0
`define DSP_RS_CTRL 1'b0
`define DSP_RS_DATA 1'b1
// Status bit positions
`define DSP_ST_RXF 0
`define DSP_ST_TXE 1
`define DSP_ST_DCD 2
`define DSP_ST_CTS 3
`define DSP_ST_FE  4
`define DSP_ST_OVR 5
`define DSP_ST_PE  6
`define DSP_ST_IRQ 7
// Control fields
`define DSP_CT_DIV 1:0
`define DSP_CT_FMT 4:2
`define DSP_CT_TXC 6:5
`define DSP_CT_RIE 7
// Divide codes and transmit control codes
`define DSP_DIV_16   2'h1
`define DSP_DIV_64   2'h2
`define DSP_DIV_MRST 2'h3
`define DSP_TXC_IE   2'h1
`define DSP_TXC_BRK  2'h3
// Control reset value: port held in master reset
`define DSP_CTRL_RST 8'h03
// Read wait state, least time rounded up to cycles
`define DSP_CLK_MHZ  50
`define DSP_WAIT_NS  500
`define DSP_WAIT_CYC ((`DSP_WAIT_NS * `DSP_CLK_MHZ + 999) / 1000)
`endif

// File: dsp_cpu_model.sv
// CPU bus model: I/O write and read machine cycles as tasks.
// Assumes the board answers on ref_clk_i and stalls reads.
`timescale 1ns/100ps
module dsp_cpu_model (
  // Clock and answers
  input  wire logic               ref_clk_i,
  input  wire dsp_pkg::dsp_byte_t rdata_i,
  input  wire logic               ready_i,
  // Requests
  output logic [7:0]              addr_o,
  output dsp_pkg::dsp_byte_t      wdata_o,
  output logic                    rd_stat_o,
  output logic                    wr_stat_o,
  output logic                    din_o,
  output logic                    wr_n_o,
  output logic                    wack_o
);
  import dsp_pkg::*;
  // Released lines flip so a stale value never looks live
  task automatic idle;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    {rd_stat_o, wr_stat_o, din_o, wack_o, wr_n_o} = 5'h01;
  endtask
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    idle();
  end
  //////////////////////////////
  // write status, strobe low
  task automatic io_wr(input logic [7:0] a, input dsp_byte_t d);
    @(posedge ref_clk_i) #1;
    addr_o = a;
    wdata_o = d;
    wr_stat_o = 1'b1;
    wr_n_o = 1'b0;
    @(posedge ref_clk_i) #1;
    idle();
  endtask
  task automatic io_rd(input logic [7:0] a, output dsp_byte_t d);
    int n;
    @(posedge ref_clk_i) #1;
    addr_o = a;
    rd_stat_o = 1'b1;
    @(posedge ref_clk_i) #1;
    din_o = 1'b1;
    wack_o = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ready_i !== 1'b1 && n < 100);
    d = rdata_i;
    #1;
    idle();
  endtask
endmodule // dsp_cpu_model

// File: dsp_pkg.sv
// Types shared by the dual serial port board modules.
// No dependencies.
package dsp_pkg;
  // Serial shift engine states, used by transmitter and receiver
  typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} dsp_ser_st_t;
  // One bus or character byte
  typedef logic [7:0] dsp_byte_t;
endpackage

// File: dsp_rate_tick.sv
// Rate tick generator: one pulse per period of the 16x serial rate clock.
// Assumes the board crystal is represented by ref_clk_i divided down.
`timescale 1ns/100ps

module dsp_rate_tick #(
  parameter int RATE_DIV = 326  // Reference clocks per rate tick
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // Tick out
  output logic      tick_o
);
  logic [15:0] cnt;  // Prescale counter

  // Free-running prescaler
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt == 16'(RATE_DIV - 1)) begin
      cnt    <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // dsp_rate_tick

// File: dsp_skid_buf.sv
// Small FIFO with valid/ready on both sides, used as the transmit holding stage.
// Assumes one clock; clr_i empties it (master reset of the port).
`timescale 1ns/100ps

module dsp_skid_buf #(
  parameter int WIDTH = 8,  // Word width
  parameter int DEPTH = 2   // Entries
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             clr_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0]    wr_ptr;       // Next write slot
  logic [AW-1:0]    rd_ptr;       // Oldest entry
  logic [AW:0]      count;        // Entries held
  logic             push;
  logic             pop;

  // Pointer advance with wrap, for any depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write, no reset needed on data
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || clr_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule // dsp_skid_buf
